// ==== rtl/plsr_regs.sv ====
// Partition identification and streaming label register bank
//
// Behaviour
// RULE1: Bit 61 reports secure-default control; when set, secure requests use partition 0.
// RULE2: Bit 60 reports force-non-secure control; when set, secure requests carry nonsecure 1.
// RULE3: Bit 59 zero means two partition spaces, one means four.
// RULE4: Bit 58 reports presence of the hypervisor trap-identification control.
// RULE5: Recommended that v0.1 and v1.1 parts report bit 58 as one.
// RULE6: Bit 57 reports whether alternative partition spaces exist.
// RULE7: Bits 39:32 hold largest monitor group; label fields must cover it.
// RULE8: Bits 20:18 give top mapping register index, zero without virtualization.
// RULE9: Bit 17 reports virtualization; zero when no hypervisor level exists.
// RULE10: Bits 15:0 hold largest partition number; label fields must cover it.
// RULE11: Identification register uses encoding 3,0,10,4,4.
// RULE12: Level 0 reads undefined; lower trap sends levels 1-2 to level 3, class 0x18.
// RULE13: Streaming register labels streaming matrix and streaming-mode vector accesses.
// RULE14: With shared streaming unit, streaming labels win over level label registers.
// RULE15: With private streaming unit, precedence is an implementation choice.
// RULE16: Streaming labels used only while level-one labelling enable is one.
// RULE17: Level-0 streaming partitions are virtual under hypervisor, no host pair, map enable.
// RULE18: Level-1 streaming partitions are virtual under hypervisor and level-1 map enable.
// RULE19: Streaming register holds 8-bit data monitor group in bits 47:40.
// RULE20: Streaming register holds 16-bit data partition in bits 31:16; rest reserved.
// RULE21: Streaming fields are unknown after warm reset; software initialises them.
// RULE22: Hypervisor ident-read trap sends level-1 identification reads to level 2.
// RULE23: A mapping entry is used only when its valid bit is set.
// RULE24: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps

module plsr_regs #(
  parameter logic        SECURE_DEFAULT_PRESENT  = 1'b1,
  parameter logic        FORCE_NONSECURE_PRESENT = 1'b1,
  parameter logic        FOUR_SPACE_SUPPORT      = 1'b0,
  parameter logic        TRAP_IDENT_CTRL_PRESENT = 1'b1,
  parameter logic        ALTERNATE_SPACE_PRESENT = 1'b0,
  parameter logic        VIRTUALIZATION_PRESENT  = 1'b1,
  parameter logic        HYP_LEVEL_PRESENT       = 1'b1,
  parameter logic [2:0]  MAPPING_REG_INDEX_LIMIT = 3'h7,
  parameter logic [7:0]  MONITOR_GROUP_LIMIT     = 8'hFF,
  parameter logic [15:0] PARTITION_NUMBER_LIMIT  = 16'hFFFF,
  parameter logic        SHARED_STREAMING_UNIT   = 1'b1,
  parameter logic        PRIVATE_UNIT_PRECEDENCE = 1'b1
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  input  wire plsr_pkg::plsr_req_t  req_i,
  input  wire plsr_pkg::plsr_ctx_t  ctx_i,
  input  wire logic                 stream_req_i,
  input  wire logic [1:0]           stream_level_i,
  input  wire logic [31:0]          map_valid_i,
  output plsr_pkg::plsr_rsp_t       rsp_o,
  output plsr_pkg::plsr_label_t     label_o
);

  // Virtualization cannot exist without a hypervisor level
  initial begin
    if (VIRTUALIZATION_PRESENT && !HYP_LEVEL_PRESENT) begin
      $error("virtualization needs a hypervisor level");
    end
  end

  typedef struct packed {
    logic [7:0]            data_monitor_group;
    logic [15:0]           data_partition_number;
    plsr_pkg::plsr_rsp_t   rsp;
    plsr_pkg::plsr_label_t label;
  } plsr_state_t;

  plsr_state_t state;
  plsr_state_t next_state;

  logic [63:0] ident_value;
  logic [63:0] stream_value;

  // Identification word is built from constants only
  always_comb begin
    ident_value = 64'h0;
    ident_value[plsr_pkg::SECURE_DEFAULT_PRESENT_BIT]  = SECURE_DEFAULT_PRESENT; // RULE1
    ident_value[plsr_pkg::FORCE_NONSECURE_PRESENT_BIT] = FORCE_NONSECURE_PRESENT; // RULE2
    ident_value[plsr_pkg::FOUR_SPACE_SUPPORT_BIT]      = FOUR_SPACE_SUPPORT; // RULE3
    ident_value[plsr_pkg::TRAP_IDENT_CTRL_PRESENT_BIT] = TRAP_IDENT_CTRL_PRESENT; // RULE4 RULE5
    ident_value[plsr_pkg::ALTERNATE_SPACE_PRESENT_BIT] = ALTERNATE_SPACE_PRESENT; // RULE6
    ident_value[plsr_pkg::MONITOR_GROUP_LIMIT_LSB +: 8] = MONITOR_GROUP_LIMIT; // RULE7
    // Index reads zero without virtualization
    ident_value[plsr_pkg::MAPPING_REG_INDEX_LIMIT_LSB +: 3] =
      VIRTUALIZATION_PRESENT ? MAPPING_REG_INDEX_LIMIT : 3'h0; // RULE8
    ident_value[plsr_pkg::VIRTUALIZATION_PRESENT_BIT] =
      VIRTUALIZATION_PRESENT & HYP_LEVEL_PRESENT; // RULE9
    ident_value[plsr_pkg::PARTITION_NUMBER_LIMIT_LSB +: 16] = PARTITION_NUMBER_LIMIT; // RULE10
    stream_value = 64'h0; // RULE24
    stream_value[plsr_pkg::DATA_MONITOR_GROUP_LSB +: 8]     = state.data_monitor_group; // RULE19
    stream_value[plsr_pkg::DATA_PARTITION_NUMBER_LSB +: 16] = state.data_partition_number; // RULE20
  end

  logic hit_ident;
  logic hit_stream;
  logic low_trap;
  logic map_ok;
  logic virt;
  logic prec;
  logic [4:0] vidx;

  always_comb begin
    next_state = state;
    next_state.rsp.done = 1'b0;
    hit_ident = req_i.enc == plsr_pkg::ENC_FEATURE_IDENT; // RULE11
    hit_stream = req_i.enc == plsr_pkg::ENC_STREAMING_LABEL;
    low_trap = ctx_i.lower_level_trap &&
               (req_i.level == plsr_pkg::LEVEL1 || req_i.level == plsr_pkg::LEVEL2);
    if (req_i.valid) begin
      next_state.rsp.done = 1'b1;
      next_state.rsp.rdata = 64'h0;
      next_state.rsp.exc_class = 6'h00;
      next_state.rsp.outcome = plsr_pkg::PLSR_OK;
      if (!(hit_ident || hit_stream) || req_i.level == plsr_pkg::LEVEL0 ||
          (hit_ident && req_i.write)) begin
        next_state.rsp.outcome = plsr_pkg::PLSR_UNDEF; // RULE12
      end else if (low_trap) begin
        // Debug halt with secure debug off must not escape to level 3
        if (ctx_i.halted && ctx_i.secure_debug_disable) begin
          next_state.rsp.outcome = plsr_pkg::PLSR_UNDEF; // RULE12
        end else begin
          next_state.rsp.outcome = plsr_pkg::PLSR_TRAP_L3; // RULE12
          next_state.rsp.exc_class = plsr_pkg::TRAP_EXCEPTION_CLASS;
        end
      end else if (hit_ident && req_i.level == plsr_pkg::LEVEL1 && ctx_i.hyp_enabled &&
                   ((VIRTUALIZATION_PRESENT && ctx_i.ident_read_trap) ||
                    (TRAP_IDENT_CTRL_PRESENT && ctx_i.trap_ident_ctrl))) begin
        next_state.rsp.outcome = plsr_pkg::PLSR_TRAP_L2; // RULE22
        next_state.rsp.exc_class = plsr_pkg::TRAP_EXCEPTION_CLASS;
      end else if (hit_ident) begin
        next_state.rsp.rdata = ident_value;
      end else if (req_i.write) begin
        // Only field bits are stored, reserved ones dropped
        next_state.data_monitor_group =
          req_i.wdata[plsr_pkg::DATA_MONITOR_GROUP_LSB +: 8]; // RULE19 RULE24
        next_state.data_partition_number =
          req_i.wdata[plsr_pkg::DATA_PARTITION_NUMBER_LSB +: 16]; // RULE20 RULE24
      end else begin
        next_state.rsp.rdata = stream_value;
      end
    end

    // Labelling of streaming requests
    prec = SHARED_STREAMING_UNIT | PRIVATE_UNIT_PRECEDENCE; // RULE14 RULE15
    vidx = state.data_partition_number[4:0];
    map_ok = map_valid_i[vidx]; // RULE23
    virt = 1'b0;
    if (ctx_i.hyp_enabled && VIRTUALIZATION_PRESENT) begin
      if (stream_level_i == plsr_pkg::LEVEL0) begin
        virt = !(ctx_i.host_hypervisor_flag && ctx_i.trap_general_flag) &&
               ctx_i.level0_virtual_map_enable; // RULE17
      end else if (stream_level_i == plsr_pkg::LEVEL1) begin
        virt = ctx_i.level1_virtual_map_enable; // RULE18
      end
    end
    next_state.label.valid = stream_req_i; // RULE13
    next_state.label.use_streaming = stream_req_i && prec && ctx_i.labelling_enable; // RULE16
    next_state.label.is_virtual = virt && map_ok;
    next_state.label.monitor_group = state.data_monitor_group;
    next_state.label.partition = state.data_partition_number;
    next_state.label.nonsecure = !ctx_i.secure_state;
    if (ctx_i.secure_state && SECURE_DEFAULT_PRESENT && ctx_i.secure_default_select) begin
      next_state.label.partition = 16'h0000; // RULE1
    end
    if (ctx_i.secure_state && FORCE_NONSECURE_PRESENT && ctx_i.force_nonsecure_select) begin
      next_state.label.nonsecure = 1'b1; // RULE2
    end
  end

  // Fields take a defined value; software must still initialise them
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= '0;
      state.data_monitor_group <= plsr_pkg::DATA_MONITOR_GROUP_RESET; // RULE21
      state.data_partition_number <= plsr_pkg::DATA_PARTITION_NUMBER_RESET; // RULE21
    end else begin
      state <= next_state;
    end
  end

  assign rsp_o = state.rsp;
  assign label_o = state.label;

endmodule

// ==== rtl/plsr_pkg.sv ====
// Package for the partition label identification and streaming label registers
package plsr_pkg;

  // System register encodings {op0, op1, crn, crm, op2}
  localparam logic [15:0] ENC_FEATURE_IDENT   = 16'hC524;
  localparam logic [15:0] ENC_STREAMING_LABEL = 16'hC52B;

  // Identification register field positions
  localparam int SECURE_DEFAULT_PRESENT_BIT  = 61;
  localparam int FORCE_NONSECURE_PRESENT_BIT = 60;
  localparam int FOUR_SPACE_SUPPORT_BIT      = 59;
  localparam int TRAP_IDENT_CTRL_PRESENT_BIT = 58;
  localparam int ALTERNATE_SPACE_PRESENT_BIT = 57;
  localparam int MONITOR_GROUP_LIMIT_LSB     = 32;
  localparam int MAPPING_REG_INDEX_LIMIT_LSB = 18;
  localparam int VIRTUALIZATION_PRESENT_BIT  = 17;
  localparam int PARTITION_NUMBER_LIMIT_LSB  = 0;

  // Streaming label register field positions
  localparam int DATA_MONITOR_GROUP_LSB    = 40;
  localparam int DATA_PARTITION_NUMBER_LSB = 16;

  // Streaming label fields reset to zero; the architected value is unknown
  localparam logic [7:0]  DATA_MONITOR_GROUP_RESET    = 8'h00;
  localparam logic [15:0] DATA_PARTITION_NUMBER_RESET = 16'h0000;

  // Exception levels
  localparam logic [1:0] LEVEL0 = 2'h0;
  localparam logic [1:0] LEVEL1 = 2'h1;
  localparam logic [1:0] LEVEL2 = 2'h2;
  localparam logic [1:0] LEVEL3 = 2'h3;

  // Exception class of a trapped system-register access
  localparam logic [5:0] TRAP_EXCEPTION_CLASS = 6'h18;

  // Access outcome
  typedef enum logic [1:0] {
    PLSR_OK,
    PLSR_UNDEF,
    PLSR_TRAP_L2,
    PLSR_TRAP_L3
  } plsr_outcome_t;

  // Register access request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] enc;
    logic [1:0]  level;
    logic [63:0] wdata;
  } plsr_req_t;

  // Architectural context that steers access and labelling
  typedef struct packed {
    logic hyp_enabled;
    logic host_hypervisor_flag;
    logic trap_general_flag;
    logic lower_level_trap;
    logic halted;
    logic secure_debug_disable;
    logic ident_read_trap;
    logic trap_ident_ctrl;
    logic level0_virtual_map_enable;
    logic level1_virtual_map_enable;
    logic labelling_enable;
    logic secure_state;
    logic secure_default_select;
    logic force_nonsecure_select;
  } plsr_ctx_t;

  // Register access response
  typedef struct packed {
    logic          done;
    plsr_outcome_t outcome;
    logic [5:0]    exc_class;
    logic [63:0]   rdata;
  } plsr_rsp_t;

  // Label attached to a streaming memory request
  typedef struct packed {
    logic        valid;
    logic        use_streaming;
    logic        is_virtual;
    logic        nonsecure;
    logic [15:0] partition;
    logic [7:0]  monitor_group;
  } plsr_label_t;

endpackage

// ==== tb/plsr_assertions.sv ====
// Port-level assertions for the partition label register bank
`timescale 1ns/1ps

module plsr_assertions (
  input wire logic                  core_clk_i,
  input wire logic                  rst_n_i,
  input wire plsr_pkg::plsr_req_t   req_i,
  input wire plsr_pkg::plsr_ctx_t   ctx_i,
  input wire logic                  stream_req_i,
  input wire logic [1:0]            stream_level_i,
  input wire logic [31:0]           map_valid_i,
  input wire plsr_pkg::plsr_rsp_t   rsp_o,
  input wire plsr_pkg::plsr_label_t label_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic rd_id;
  logic rd_st;
  assign rd_id = req_i.valid && !req_i.write && req_i.enc == plsr_pkg::ENC_FEATURE_IDENT;
  assign rd_st = req_i.valid && !req_i.write && req_i.enc == plsr_pkg::ENC_STREAMING_LABEL;
  answer_next_a: assert property (req_i.valid |=> rsp_o.done)
    else $error("request not answered");
  level0_undef_a: assert property (req_i.valid && req_i.level == plsr_pkg::LEVEL0
    |=> rsp_o.outcome == plsr_pkg::PLSR_UNDEF) else $error("level 0 access allowed");
  lower_trap_a: assert property (rd_id && req_i.level == plsr_pkg::LEVEL1
    && ctx_i.lower_level_trap && !ctx_i.halted
    |=> rsp_o.outcome == plsr_pkg::PLSR_TRAP_L3 && rsp_o.exc_class == 6'h18)
    else $error("lower trap missed");
  ident_trap_a: assert property (rd_id && req_i.level == plsr_pkg::LEVEL1
    && !ctx_i.lower_level_trap && ctx_i.hyp_enabled && ctx_i.ident_read_trap
    |=> rsp_o.outcome == plsr_pkg::PLSR_TRAP_L2) else $error("ident trap missed");
  stream_resv_a: assert property (rd_st && req_i.level == plsr_pkg::LEVEL3
    |=> rsp_o.rdata[63:48] == 16'h0 && rsp_o.rdata[39:32] == 8'h0 && rsp_o.rdata[15:0] == 16'h0)
    else $error("reserved bits set");
  label_gate_a: assert property (stream_req_i && !ctx_i.labelling_enable
    |=> label_o.valid && !label_o.use_streaming) else $error("label used while disabled");
  sec_default_a: assert property (stream_req_i && ctx_i.secure_state
    && ctx_i.secure_default_select |=> label_o.partition == 16'h0000)
    else $error("secure default ignored");
  map_l1_a: assert property (stream_req_i && stream_level_i == plsr_pkg::LEVEL1
    && ctx_i.labelling_enable && (&map_valid_i)
    |=> label_o.is_virtual == $past(ctx_i.hyp_enabled && ctx_i.level1_virtual_map_enable))
    else $error("level 1 mapping wrong");
  map_invalid_a: assert property (stream_req_i && map_valid_i == 32'h0
    |=> !label_o.is_virtual) else $error("invalid entry used");
endmodule

bind plsr_regs plsr_assertions u_chk (.core_clk_i, .rst_n_i, .req_i, .ctx_i, .stream_req_i,
  .stream_level_i, .map_valid_i, .rsp_o, .label_o);

// ==== tb/plsr_mem_sink.sv ====
// Memory-side sink that takes labelled streaming requests
`timescale 1ns/1ps

module plsr_mem_sink (
  input  wire logic                  core_clk_i,
  input  wire plsr_pkg::plsr_label_t label_i,
  output plsr_pkg::plsr_label_t      last_o,
  output int                         seen_o
);
  // No back-pressure on this path, so every valid label is taken
  initial seen_o = 0;
  always @(posedge core_clk_i) begin
    if (label_i.valid === 1'b1) begin
      last_o <= label_i;
      seen_o <= seen_o + 1;
    end
  end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the partition label register bank
`timescale 1ns/1ps

module testbench;
  // Default build: all but four spaces and alternate spaces
  localparam logic [63:0] IDENT = {2'h0, 4'hD, 1'b0, 17'h0, 8'hFF, 11'h0, 3'h7, 2'h2, 16'hFFFF};
  localparam logic [63:0] SMASK = 64'h0000_FF00_FFFF_0000;
  localparam logic [15:0] ID    = plsr_pkg::ENC_FEATURE_IDENT;
  localparam logic [15:0] ST    = plsr_pkg::ENC_STREAMING_LABEL;
  logic                  core_clk_i = 1'b0;
  logic                  rst_n_i = 1'b0;
  logic                  stream_req_i = 1'b0;
  logic [1:0]            stream_level_i = 2'h0;
  logic [31:0]           map_valid_i = 32'h0;
  plsr_pkg::plsr_req_t   req_i = '0;
  plsr_pkg::plsr_ctx_t   ctx_i = '0;
  plsr_pkg::plsr_rsp_t   rsp_o;
  plsr_pkg::plsr_label_t label_o, last, e;
  logic [27:0]           m;
  logic [63:0]           d;
  int                    seen, failures = 0, compares = 0;
  always #5 core_clk_i = ~core_clk_i;
  plsr_regs u_dut (.core_clk_i, .rst_n_i, .req_i, .ctx_i, .stream_req_i, .stream_level_i,
    .map_valid_i, .rsp_o, .label_o);
  plsr_mem_sink u_sink (.core_clk_i, .label_i(label_o), .last_o(last), .seen_o(seen));
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] en, input logic [1:0] l,
                     input logic [63:0] wd, input plsr_pkg::plsr_outcome_t o);
    @(posedge core_clk_i);
    req_i <= '{valid: 1'b1, write: w, enc: en, level: l, wdata: wd};
    @(posedge core_clk_i);
    req_i.valid <= 1'b0;
    // Done stands for one cycle only, so look before the next edge
    #1;
    chk(rsp_o.done === 1'b1 && rsp_o.outcome === o, "access outcome");
  endtask
  function automatic plsr_pkg::plsr_label_t lab_exp(plsr_pkg::plsr_ctx_t c, logic [1:0] l,
                                                    logic [31:0] mv, logic [63:0] r);
    logic vc;
    lab_exp = '0;
    lab_exp.valid = 1'b1;
    lab_exp.use_streaming = c.labelling_enable;
    lab_exp.nonsecure = !c.secure_state || c.force_nonsecure_select;
    lab_exp.partition = (c.secure_state && c.secure_default_select) ? 16'h0 : r[31:16];
    lab_exp.monitor_group = r[47:40];
    vc = c.hyp_enabled && ((l == plsr_pkg::LEVEL1) ? c.level1_virtual_map_enable :
         (l == plsr_pkg::LEVEL0) && c.level0_virtual_map_enable &&
         !(c.host_hypervisor_flag && c.trap_general_flag));
    lab_exp.is_virtual = vc && mv[lab_exp.partition[4:0]];
  endfunction
  task automatic tally_and_finish();
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(91274));
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    acc(1'b1, ST, plsr_pkg::LEVEL0, '1, plsr_pkg::PLSR_UNDEF);
    acc(1'b0, ST, plsr_pkg::LEVEL3, '0, plsr_pkg::PLSR_OK);
    chk(rsp_o.rdata === 64'h0, "stream reset value");
    acc(1'b0, ID, plsr_pkg::LEVEL2, '0, plsr_pkg::PLSR_OK);
    chk(rsp_o.rdata === IDENT, "ident value");
    acc(1'b1, ID, plsr_pkg::LEVEL3, '1, plsr_pkg::PLSR_UNDEF);
    acc(1'b0, 16'h0000, plsr_pkg::LEVEL3, '0, plsr_pkg::PLSR_UNDEF);
    @(posedge core_clk_i) ctx_i <= '{hyp_enabled: 1'b1, ident_read_trap: 1'b1, default: 1'b0};
    acc(1'b0, ID, plsr_pkg::LEVEL1, '0, plsr_pkg::PLSR_TRAP_L2);
    acc(1'b0, ID, plsr_pkg::LEVEL2, '0, plsr_pkg::PLSR_OK);
    @(posedge core_clk_i) ctx_i.lower_level_trap <= 1'b1;
    acc(1'b0, ID, plsr_pkg::LEVEL1, '0, plsr_pkg::PLSR_TRAP_L3);
    chk(rsp_o.exc_class === plsr_pkg::TRAP_EXCEPTION_CLASS, "trap class");
    @(posedge core_clk_i) ctx_i.halted <= 1'b1;
    @(posedge core_clk_i) ctx_i.secure_debug_disable <= 1'b1;
    acc(1'b0, ID, plsr_pkg::LEVEL2, '0, plsr_pkg::PLSR_UNDEF);
    for (int i = 0; i < 60; i++) begin
      d = (i == 0) ? '1 : {$urandom, $urandom};
      acc(1'b1, ST, plsr_pkg::LEVEL3, d, plsr_pkg::PLSR_OK);
      acc(1'b0, ST, plsr_pkg::LEVEL3, '0, plsr_pkg::PLSR_OK);
      chk(rsp_o.rdata === (d & SMASK), "stream readback");
      @(posedge core_clk_i);
      ctx_i <= 14'($urandom);
      stream_level_i <= 2'($urandom);
      map_valid_i <= (i % 3 == 0) ? '1 : (i % 3 == 1) ? '0 : $urandom;
      stream_req_i <= 1'b1;
      @(posedge core_clk_i) stream_req_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      #1;
      e = lab_exp(ctx_i, stream_level_i, map_valid_i, d);
      // Fields beyond the enable are open while labelling is off
      m = ctx_i.labelling_enable ? 28'hFFFFFFF : 28'hC000000;
      if (ctx_i.secure_state && ctx_i.secure_default_select) m[25] = 1'b0;
      chk(((last ^ e) & m) === 28'h0 && seen == i + 1, "label");
    end
    tally_and_finish();
  end
  initial begin
    #100us;
    failures++;
    tally_and_finish();
  end
endmodule
